// >>> iew_cpu_model.sv
// model: cpu core side issuing byte accesses to the event unit
module iew_cpu_model (
	input  wire logic        CLK,
	input  wire logic [7:0]  RDATA,
	output logic      [15:0] ADDR,
	output logic      [7:0]  WDATA,
	output logic             WR_EN,
	output logic             RD_EN,
	output logic             BIT_OP
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {ADDR, WDATA, WR_EN, RD_EN, BIT_OP} = '0;
	// ----
	// accesses, entered just after a falling edge
	// ----
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
		// one idle edge between accesses, so a strobe never drops and rises in one step
		@(negedge CLK);
		ADDR = a;
		WDATA = d;
		BIT_OP = b;
		WR_EN = 1'b1;
		@(negedge CLK);
		WR_EN = 1'b0;
		BIT_OP = 1'b0;
		// a released data bus must not keep its last value
		WDATA = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge CLK);
		ADDR = a;
		RD_EN = 1'b1;
		@(negedge CLK);
		RD_EN = 1'b0;
		d = RDATA;
	endtask
	// the watchdog bit only clears behind the key
	task automatic clear_all;
		wr(16'h00F9, 8'hA6, 1'b0);
		wr(16'h00E3, 8'h00, 1'b0);
	endtask
endmodule

// >>> iew_edge_detect.sv
// module: registered falling edge finder for the port zero pins in input mode
module iew_edge_detect (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] pins,
	input  wire logic [7:0] input_mode,
	output logic            fell
);
	typedef struct packed {
		logic [7:0] prev;
		logic       fell;
	} iew_edge_state_t;

	iew_edge_state_t state_reg;
	iew_edge_state_t state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.prev = pins;
		// output pins are masked so a driven level never looks like an edge
		state_next.fell = |(state_reg.prev & ~pins & input_mode);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg.prev <= iew_pkg::PORT_ZERO_IDLE;
			state_reg.fell <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign fell = state_reg.fell;
endmodule

// >>> iew_event_chk.sv
// checker: port-level properties of the event and unlock unit
module iew_event_chk (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR_EN,
	input wire logic        RD_EN,
	input wire logic        BIT_OP,
	input wire logic        TIMER_UNDERFLOW,
	input wire logic [7:0]  CPU_STATUS,
	input wire logic        MASKABLE_REQUEST_LINE,
	input wire logic        IRQ_TAKEN_REQ,
	input wire logic        RDATA_VALID,
	input wire logic        WATCHDOG_COUNTER_CLEAR,
	input wire logic        OSCILLATOR_FREEZE_BIT,
	input wire logic [7:0]  OSCILLATOR_TRIM_REG,
	input wire logic        UNLOCK_ACTIVE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] en_reg;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// the mask is write-only, so the checker keeps its own copy
	always_ff @(posedge CLK) begin
		if (SYS_RST) en_reg <= 8'h00;
		else if (WR_EN && !BIT_OP && ADDR == 16'h00E2) en_reg <= WDATA;
	end
	// ----
	// assertions
	// ----
	sequence s_key;
		WR_EN && !BIT_OP && ADDR == 16'h00F9 && WDATA == 8'hA6;
	endsequence
	sequence s_wd_clr;
		WR_EN && !BIT_OP && ADDR == 16'h00E3 && !WDATA[5];
	endsequence
	timer_req_a: assert property (TIMER_UNDERFLOW && en_reg[3] |=> MASKABLE_REQUEST_LINE)
		else $error("timer request missing");
	idis_mask_a: assert property (CPU_STATUS[2] && $past(CPU_STATUS[2]) |-> !IRQ_TAKEN_REQ)
		else $error("request taken while disabled");
	key_arm_a: assert property (s_key |=> UNLOCK_ACTIVE)
		else $error("key not armed");
	unlock_drop_a: assert property (UNLOCK_ACTIVE && WR_EN && !BIT_OP && !(ADDR == 16'h00F9
		&& WDATA == 8'hA6) |=> !UNLOCK_ACTIVE)
		else $error("unlock outlived its write");
	wd_clear_a: assert property (s_key ##1 s_wd_clr |=> WATCHDOG_COUNTER_CLEAR)
		else $error("watchdog clear lost");
	wd_locked_a: assert property (!UNLOCK_ACTIVE ##0 s_wd_clr |=> !WATCHDOG_COUNTER_CLEAR)
		else $error("watchdog cleared while locked");
	trim_lock_a: assert property (!UNLOCK_ACTIVE |=> $stable(OSCILLATOR_TRIM_REG)
		&& $stable(OSCILLATOR_FREEZE_BIT))
		else $error("guarded register changed while locked");
	read_ack_a: assert property (RD_EN && !BIT_OP && ADDR[15:5] == 11'h007 |=> RDATA_VALID)
		else $error("read not answered");
endmodule

// >>> iew_event_unit.sv
// module: interrupt event flags, enable mask and write-unlock guard of the microcontroller
//
// Contract
// - three maskable sources: port zero edge, timer underflow, divider carry, each enabled
// - maskable requests use the shared vector; resets use the reset vector pair
// - a source requests only while its enable and its flag are both one
// - enable register write-only, divider bit 4, timer bit 3, port bit 0, reset zero
// - port zero flag set by falling edge on an input-mode pin, sticky
// - divider flag set on each carry-out, sticky until software clears
// - timer flag set on underflow, sticky until software clears
// - watchdog flag set on time-out; its clear also clears the watchdog counter
// - low-voltage flag bit 6 is read-only and follows the detector
// - reading the event address returns the flags; flags are not writable
// - writing the event address clears each flag whose bit is written zero, except the low-voltage flag and, while locked, the watchdog flag
// - watchdog clear bit honoured only while unlocked
// - key pattern must precede watchdog clear, freeze or trim changes
// - unlock self-clears after the next firmware write
// - special registers at E0 to FF, whole-byte accesses only
// - cpu interrupt-disable bit masks all maskable requests at IRQ_TAKEN_REQ; MASKABLE_REQUEST_LINE stays unmasked
module iew_event_unit (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	input  wire logic        BIT_OP,
	output logic      [7:0]  RDATA,
	output logic             RDATA_VALID,
	input  wire logic [7:0]  PORT_ZERO_PINS,
	input  wire logic [3:0]  PORT_ZERO_DIR,
	input  wire logic        TIMER_UNDERFLOW,
	input  wire logic        DIVIDER_CARRY,
	input  wire logic        WATCHDOG_TIMEOUT,
	input  wire logic        LOW_VOLTAGE_IN,
	input  wire logic [7:0]  CPU_STATUS,
	output logic             MASKABLE_REQUEST_LINE,
	output logic             IRQ_TAKEN_REQ,
	output logic      [15:0] IRQ_VECTOR,
	output logic      [15:0] RESET_VECTOR,
	output logic             WATCHDOG_COUNTER_CLEAR,
	output logic             OSCILLATOR_FREEZE_BIT,
	output logic      [7:0]  OSCILLATOR_TRIM_REG,
	output logic             UNLOCK_ACTIVE
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  irq_enable_mask;
		logic        port_zero_event;
		logic        timer_event;
		logic        divider_event;
		logic        watchdog_event;
		logic        low_voltage_flag;
		logic        unlocked;
		logic        osc_freeze;
		logic [7:0]  osc_trim;
		logic [7:0]  rdata;
		logic        rdata_valid;
		logic        request;
		logic        taken;
		logic        wdt_clear;
		logic [15:0] irq_vector;
		logic [15:0] reset_vector;
	} iew_state_t;

	iew_state_t state_reg;
	iew_state_t state_next;

	logic [7:0] input_mode;
	logic       port_fell;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic sfr_hit(input logic [15:0] a, input logic [15:0] off,
			input logic bitop);
		// bit-manipulation cycles never reach the special registers
		sfr_hit = (a == off) && !bitop;
	endfunction

	function automatic logic next_flag(input logic cur, input logic set,
			input logic clr);
		next_flag = set | (cur & ~clr);
	endfunction

	// port pins 0..3 are input only; 4..7 follow the direction bits
	assign input_mode = {~PORT_ZERO_DIR, 4'hF};

	iew_edge_detect u_edge (
		.clk        (CLK),
		.rst        (SYS_RST),
		.pins       (PORT_ZERO_PINS),
		.input_mode (input_mode),
		.fell       (port_fell)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic       in_sfr;
		logic       wr_enable;
		logic       wr_event;
		logic       wr_key;
		logic       wr_trim;
		logic       wr_clock;
		logic       rd_event;
		logic       clr_port;
		logic       clr_timer;
		logic       clr_div;
		logic       clr_wdt;
		logic [2:0] pending;

		in_sfr    = (ADDR >= iew_pkg::SFR_FIRST) && (ADDR <= iew_pkg::SFR_LAST);
		wr_enable = WR_EN && sfr_hit(ADDR, iew_pkg::OFF_IRQ_ENABLE, BIT_OP);
		wr_event  = WR_EN && sfr_hit(ADDR, iew_pkg::OFF_EVENT, BIT_OP);
		wr_key    = WR_EN && sfr_hit(ADDR, iew_pkg::OFF_UNLOCK_KEY, BIT_OP);
		wr_trim   = WR_EN && sfr_hit(ADDR, iew_pkg::OFF_OSC_TRIM, BIT_OP);
		wr_clock  = WR_EN && sfr_hit(ADDR, iew_pkg::OFF_CLOCK_MANAGER, BIT_OP);
		rd_event  = RD_EN && sfr_hit(ADDR, iew_pkg::OFF_EVENT, BIT_OP);

		state_next = state_reg;

		if (wr_enable) begin
			state_next.irq_enable_mask = WDATA & iew_pkg::ENABLE_MASK;
		end

		// a zero written to a bit clears that flag; the watchdog flag only while unlocked
		clr_port  = wr_event && !WDATA[iew_pkg::BIT_PORT_ZERO];
		clr_timer = wr_event && !WDATA[iew_pkg::BIT_TIMER];
		clr_div   = wr_event && !WDATA[iew_pkg::BIT_DIVIDER];
		clr_wdt   = wr_event && !WDATA[iew_pkg::BIT_WATCHDOG] && state_reg.unlocked;

		state_next.port_zero_event = next_flag(state_reg.port_zero_event, port_fell,
			clr_port);
		state_next.timer_event     = next_flag(state_reg.timer_event, TIMER_UNDERFLOW,
			clr_timer);
		state_next.divider_event   = next_flag(state_reg.divider_event, DIVIDER_CARRY,
			clr_div);
		state_next.watchdog_event  = next_flag(state_reg.watchdog_event, WATCHDOG_TIMEOUT,
			clr_wdt);
		state_next.wdt_clear       = clr_wdt;
		state_next.low_voltage_flag = LOW_VOLTAGE_IN;
		// vectors are held in flops so every output leaves a register
		state_next.irq_vector      = iew_pkg::VEC_IRQ;
		state_next.reset_vector    = iew_pkg::VEC_RESET;

		// protected targets change only while the key is armed
		if (wr_trim && state_reg.unlocked) begin
			state_next.osc_trim = WDATA;
		end
		if (wr_clock && state_reg.unlocked) begin
			state_next.osc_freeze = WDATA[iew_pkg::BIT_OSC_FREEZE];
		end

		// the key covers exactly one following write of any kind
		if (wr_key) begin
			state_next.unlocked = (WDATA == iew_pkg::UNLOCK_PATTERN);
		end else if (WR_EN) begin
			state_next.unlocked = 1'b0;
		end

		state_next.rdata_valid = RD_EN;
		if (rd_event) begin
			state_next.rdata = {1'b0, state_reg.low_voltage_flag, state_reg.watchdog_event,
				state_reg.divider_event, state_reg.timer_event, 2'b00,
				state_reg.port_zero_event};
		end else begin
			// other registers of the window are write-only and read as zero
			state_next.rdata = 8'h00;
		end
		if (!in_sfr) begin
			state_next.rdata_valid = 1'b0;
		end

		pending = {state_next.divider_event & state_next.irq_enable_mask[iew_pkg::BIT_DIVIDER],
			state_next.timer_event & state_next.irq_enable_mask[iew_pkg::BIT_TIMER],
			state_next.port_zero_event
				& state_next.irq_enable_mask[iew_pkg::BIT_PORT_ZERO]};
		state_next.request = |pending;
		state_next.taken   = (|pending) && !CPU_STATUS[iew_pkg::BIT_CPU_IDIS];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_reg                  <= '0;
			state_reg.irq_enable_mask  <= iew_pkg::ENABLE_RESET;
			state_reg.osc_trim         <= iew_pkg::TRIM_RESET;
			state_reg.irq_vector       <= iew_pkg::VEC_IRQ;
			state_reg.reset_vector     <= iew_pkg::VEC_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign RDATA                  = state_reg.rdata;
	assign RDATA_VALID            = state_reg.rdata_valid;
	assign MASKABLE_REQUEST_LINE  = state_reg.request;
	assign IRQ_TAKEN_REQ          = state_reg.taken;
	assign IRQ_VECTOR             = state_reg.irq_vector;
	assign RESET_VECTOR           = state_reg.reset_vector;
	assign WATCHDOG_COUNTER_CLEAR = state_reg.wdt_clear;
	assign OSCILLATOR_FREEZE_BIT  = state_reg.osc_freeze;
	assign OSCILLATOR_TRIM_REG    = state_reg.osc_trim;
	assign UNLOCK_ACTIVE          = state_reg.unlocked;
endmodule

// >>> iew_pkg.sv
// package: register map, field positions and reset values of the event and unlock unit
package iew_pkg;
	// ----------------------------------------
	// register offsets (page zero data space)
	// ----------------------------------------
	localparam logic [15:0] SFR_FIRST          = 16'h00E0;
	localparam logic [15:0] SFR_LAST           = 16'h00FF;
	localparam logic [15:0] OFF_CLOCK_MANAGER  = 16'h00E0;
	localparam logic [15:0] OFF_IRQ_ENABLE     = 16'h00E2;
	localparam logic [15:0] OFF_EVENT          = 16'h00E3;
	localparam logic [15:0] OFF_OSC_TRIM       = 16'h00EF;
	localparam logic [15:0] OFF_UNLOCK_KEY     = 16'h00F9;
	// ----------------------------------------
	// vectors
	// ----------------------------------------
	localparam logic [15:0] VEC_IRQ            = 16'hFFFE;
	localparam logic [15:0] VEC_RESET          = 16'hFFFC;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_PORT_ZERO  = 0;
	localparam int BIT_CPU_IDIS   = 2;
	localparam int BIT_TIMER      = 3;
	localparam int BIT_DIVIDER    = 4;
	localparam int BIT_WATCHDOG   = 5;
	localparam int BIT_LOW_VOLT   = 6;
	localparam int BIT_OSC_FREEZE = 0;
	// ----------------------------------------
	// values
	// ----------------------------------------
	localparam logic [7:0] UNLOCK_PATTERN   = 8'hA6;
	localparam logic [7:0] ENABLE_RESET     = 8'h00;
	localparam logic [7:0] ENABLE_MASK      = 8'h19;
	localparam logic [7:0] TRIM_RESET       = 8'h00;
	localparam logic [3:0] PORT_DIR_RESET   = 4'h0;
	localparam logic [7:0] PORT_ZERO_IDLE   = 8'hFF;
endpackage

// >>> tb.sv
// testbench: event flags, request line and write-unlock guard
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] en;
		logic       bop;
		logic [3:0] dir;
		logic [4:0] src;
		logic [7:0] flags;
		logic       req;
	} iew_row_t;
	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [15:0] ADDR, IRQ_VECTOR, RESET_VECTOR;
	logic [7:0]  WDATA, RDATA, OSCILLATOR_TRIM_REG, d;
	logic [7:0]  PORT_ZERO_PINS = 8'hFF;
	logic [7:0]  CPU_STATUS = 8'h00;
	logic [3:0]  PORT_ZERO_DIR = 4'h0;
	logic        WR_EN, RD_EN, BIT_OP, RDATA_VALID, MASKABLE_REQUEST_LINE, IRQ_TAKEN_REQ;
	logic        TIMER_UNDERFLOW = 1'b0, DIVIDER_CARRY = 1'b0;
	logic        WATCHDOG_TIMEOUT = 1'b0, LOW_VOLTAGE_IN = 1'b0;
	logic        WATCHDOG_COUNTER_CLEAR, OSCILLATOR_FREEZE_BIT, UNLOCK_ACTIVE;
	int          error_cnt = 0;
	int          cmp_count = 0;
	// src: pin four falls, divider, timer, watchdog, low voltage
	iew_row_t    rows [7] = '{
		'{8'h08, 1'b0, 4'h0, 5'b00100, 8'h08, 1'b1},
		'{8'h10, 1'b0, 4'h0, 5'b01000, 8'h10, 1'b1},
		'{8'h01, 1'b0, 4'h0, 5'b10000, 8'h01, 1'b1},
		'{8'h01, 1'b0, 4'h1, 5'b10000, 8'h00, 1'b0},
		'{8'h00, 1'b0, 4'h0, 5'b01100, 8'h18, 1'b0},
		'{8'h08, 1'b1, 4'h0, 5'b00100, 8'h08, 1'b0},
		'{8'h19, 1'b0, 4'h0, 5'b00011, 8'h60, 1'b0}};
	iew_event_unit u_iew_event_unit (.*);
	iew_cpu_model  u_iew_cpu_model (.*);
	always #5 CLK = ~CLK;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude;
		if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ----
	// reset checks, table cases, then hand-written ones
	// ----
	initial begin
		repeat (5) @(negedge CLK);
		SYS_RST = 1'b0;
		chk("reset state", 8'h00, {4'h0, UNLOCK_ACTIVE, RDATA_VALID, MASKABLE_REQUEST_LINE,
			WATCHDOG_COUNTER_CLEAR});
		chk("irq vector hi", 8'hFF, IRQ_VECTOR[15:8]);
		chk("irq vector lo", 8'hFE, IRQ_VECTOR[7:0]);
		chk("reset vector hi", 8'hFF, RESET_VECTOR[15:8]);
		chk("reset vector lo", 8'hFC, RESET_VECTOR[7:0]);
		foreach (rows[i]) begin
			u_iew_cpu_model.clear_all();
			PORT_ZERO_DIR = rows[i].dir;
			u_iew_cpu_model.wr(16'h00E2, rows[i].en, rows[i].bop);
			{PORT_ZERO_PINS[4], DIVIDER_CARRY, TIMER_UNDERFLOW, WATCHDOG_TIMEOUT,
				LOW_VOLTAGE_IN} = rows[i].src ^ 5'b10000;
			@(negedge CLK);
			{PORT_ZERO_PINS[4], DIVIDER_CARRY, TIMER_UNDERFLOW, WATCHDOG_TIMEOUT} = 4'b1000;
			repeat (3) @(negedge CLK);
			u_iew_cpu_model.rd(16'h00E3, d);
			chk("flags", rows[i].flags, d);
			chk("request", {7'h00, rows[i].req}, {7'h00, MASKABLE_REQUEST_LINE});
			chk("taken", {7'h00, rows[i].req}, {7'h00, IRQ_TAKEN_REQ});
		end
		LOW_VOLTAGE_IN = 1'b0;
		repeat (2) @(negedge CLK);
		TIMER_UNDERFLOW = 1'b1;
		u_iew_cpu_model.wr(16'h00E3, 8'h00, 1'b0);
		TIMER_UNDERFLOW = 1'b0;
		u_iew_cpu_model.rd(16'h00E3, d);
		chk("set wins", 8'h28, d);
		CPU_STATUS = 8'h04;
		repeat (2) @(negedge CLK);
		chk("masked", 8'h00, {7'h00, IRQ_TAKEN_REQ});
		CPU_STATUS = 8'h00;
		u_iew_cpu_model.wr(16'h00E3, 8'hF7, 1'b0);
		u_iew_cpu_model.rd(16'h00E3, d);
		chk("ones kept", 8'h20, d);
		chk("request off", 8'h00, {7'h00, MASKABLE_REQUEST_LINE});
		u_iew_cpu_model.rd(16'h00E1, d);
		chk("empty slot", 8'h00, d);
		u_iew_cpu_model.wr(16'h00F9, 8'hA6, 1'b0);
		u_iew_cpu_model.wr(16'h00EF, 8'h5A, 1'b0);
		u_iew_cpu_model.wr(16'h00EF, 8'h33, 1'b0);
		u_iew_cpu_model.wr(16'h00E0, 8'h01, 1'b0);
		chk("trim", 8'h5A, OSCILLATOR_TRIM_REG);
		chk("freeze locked", 8'h00, {7'h00, OSCILLATOR_FREEZE_BIT});
		u_iew_cpu_model.wr(16'h00F9, 8'hA6, 1'b0);
		u_iew_cpu_model.wr(16'h00E0, 8'h01, 1'b0);
		chk("freeze", 8'h01, {7'h00, OSCILLATOR_FREEZE_BIT});
		SYS_RST = 1'b1;
		repeat (5) @(negedge CLK);
		SYS_RST = 1'b0;
		TIMER_UNDERFLOW = 1'b1;
		@(negedge CLK);
		TIMER_UNDERFLOW = 1'b0;
		@(negedge CLK);
		chk("trim reset", 8'h00, OSCILLATOR_TRIM_REG);
		chk("freeze reset", 8'h00, {7'h00, OSCILLATOR_FREEZE_BIT});
		chk("mask reset", 8'h00, {7'h00, MASKABLE_REQUEST_LINE});
		conclude();
	end
	initial begin
		#20us;
		error_cnt++;
		conclude();
	end
endmodule
bind iew_event_unit iew_event_chk u_iew_event_chk (.*);
